// [rtl/cbss_pkg.sv]
// Constants for the secondary status and bus number register block
package cbss_pkg;
  // Configuration space offsets (byte addresses)
  localparam logic [7:0] OFS_SEC_STATUS = 8'h16;
  localparam logic [7:0] OFS_PRIM_BUS = 8'h18;
  localparam logic [7:0] OFS_SEC_BUS = 8'h19;
  localparam logic [7:0] OFS_SUB_BUS = 8'h1A;

  // Secondary status field positions
  localparam int BIT_SEC_PARITY = 15;
  localparam int BIT_CARD_SYSERR = 14;
  localparam int BIT_RX_MASTER_ABORT = 13;
  localparam int BIT_RX_TARGET_ABORT = 12;
  localparam int BIT_TX_TARGET_ABORT = 11;
  localparam int BIT_SELECT_TIMING_LO = 9;
  localparam int BIT_MASTER_DATA_PARITY = 8;

  // Flag index order used on the set and clear vectors
  localparam int NUM_FLAGS = 6;
  localparam int FLG_MDPAR = 0;
  localparam int FLG_TX_TA = 1;
  localparam int FLG_RX_TA = 2;
  localparam int FLG_RX_MA = 3;
  localparam int FLG_SYSERR = 4;
  localparam int FLG_PARITY = 5;
  localparam int FLAG_POS [NUM_FLAGS] = '{BIT_MASTER_DATA_PARITY,
    BIT_TX_TARGET_ABORT, BIT_RX_TARGET_ABORT, BIT_RX_MASTER_ABORT,
    BIT_CARD_SYSERR, BIT_SEC_PARITY};

  // Reset and hard-wired values
  localparam logic [1:0] SELECT_TIMING_CODE = 2'h1;
  localparam logic [15:0] SEC_STATUS_RESET = 16'h0200;
  localparam logic [15:0] SEC_STATUS_FLAG_MASK = 16'hF900;
  localparam logic [7:0] BUS_NUM_RESET = 8'h00;
endpackage

// [rtl/cbss_flag_if.sv]
// Per-socket link between register front end and status flags
`timescale 1ns/100ps
`default_nettype none
interface cbss_flag_if;
  logic [cbss_pkg::NUM_FLAGS-1:0] set_flags;
  logic [cbss_pkg::NUM_FLAGS-1:0] clr_flags;
  logic [15:0] status;
  modport ctrl (output set_flags, output clr_flags, input status);
  modport flag (input set_flags, input clr_flags, output status);
endinterface
`default_nettype wire

// [rtl/cbss_status_flags.sv]
// Secondary status register of one socket function
`timescale 1ns/100ps
`default_nettype none
module cbss_status_flags (
  input wire logic sys_clk,
  input wire logic resetn,
  cbss_flag_if.flag fi
);
  logic [15:0] status;
  logic [15:0] next_status;

  always_comb begin
    next_status = status;
    for (int i = 0; i < cbss_pkg::NUM_FLAGS; i++) begin
      if (fi.clr_flags[i]) begin
        next_status[cbss_pkg::FLAG_POS[i]] = 1'b0; // [RULE_13]
      end
      // Set after clear so a same-cycle event is kept
      if (fi.set_flags[i]) begin
        next_status[cbss_pkg::FLAG_POS[i]] = 1'b1;
      end
    end
    // Hard-wired fields ignore writes and events
    next_status = (next_status & cbss_pkg::SEC_STATUS_FLAG_MASK)
      | cbss_pkg::SEC_STATUS_RESET; // [RULE_07] [RULE_09] [RULE_14]
  end

  // Only the global reset clears the sticky flags
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status <= cbss_pkg::SEC_STATUS_RESET; // [RULE_15]
    end else begin
      status <= next_status;
    end
  end

  assign fi.status = status;

  a_fixed_fields: assert property (@(posedge sys_clk) disable iff (!resetn)
    (status & ~cbss_pkg::SEC_STATUS_FLAG_MASK) == 16'h0200) // [RULE_10]
    else $error("hard-wired status bits changed");
  a_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
    fi.set_flags[cbss_pkg::FLG_PARITY] |=> status[15]) // [RULE_01]
    else $error("parity event lost");
  a_clear_one: assert property (@(posedge sys_clk) disable iff (!resetn)
    fi.clr_flags[3] && !fi.set_flags[3] |=> !status[13]) // [RULE_13]
    else $error("write one did not clear flag");
  a_keep_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    status[12] && !fi.clr_flags[2] |=> status[12]) // [RULE_14]
    else $error("flag lost without clear");
  a_no_spurious: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(status[11]) |-> $past(fi.set_flags[1])) // [RULE_06]
    else $error("flag set without event");
  c_set_clear: cover property (@(posedge sys_clk) disable iff (!resetn)
    fi.set_flags[5] && fi.clr_flags[5]);
endmodule
`default_nettype wire

// [rtl/cbss_fwd_decode.sv]
// Configuration cycle forwarding decision per socket
`timescale 1ns/100ps
`default_nettype none
module cbss_fwd_decode #(
  parameter int NUM_SOCK = 2
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req,
  input wire logic [7:0] bus,
  input wire logic [7:0] prim,
  input wire logic [NUM_SOCK-1:0][7:0] sec,
  input wire logic [NUM_SOCK-1:0][7:0] sub,
  output logic valid,
  output logic [NUM_SOCK-1:0] hit_local,
  output logic [NUM_SOCK-1:0] hit_pass
);
  logic [NUM_SOCK-1:0] next_local;
  logic [NUM_SOCK-1:0] next_pass;

  for (genvar g = 0; g < NUM_SOCK; g++) begin : g_sock
    // Primary and secondary numbers decide a local hit; all three decide a pass
    assign next_local[g] = req && bus != prim
      && bus == sec[g]; // [RULE_19] [RULE_21]
    assign next_pass[g] = req && bus != prim && bus > sec[g]
      && bus <= sub[g]; // [RULE_20] [RULE_21]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      valid <= 1'b0;
      hit_local <= '0;
      hit_pass <= '0;
    end else begin
      valid <= req;
      hit_local <= next_local;
      hit_pass <= next_pass;
    end
  end

  a_local_hit: assert property (@(posedge sys_clk) disable iff (!resetn)
    req && bus == sec[0] && bus != prim |=> hit_local[0]) // [RULE_21]
    else $error("secondary bus cycle not claimed");
  a_pass_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    hit_pass[0] |-> $past(bus) > $past(sec[0])
      && $past(bus) <= $past(sub[0])) // [RULE_19]
    else $error("pass outside bus range");
  c_pass: cover property (@(posedge sys_clk) disable iff (!resetn)
    hit_pass[0]);
endmodule
`default_nettype wire

// [rtl/cbss_top.sv]
// Secondary status and bus number registers of a CardBus bridge
// Functional notes
// RULE_01: Set secondary parity flag, bit 15, on address or data parity error.
// RULE_02: Set card system error flag, bit 14, when card asserts system error.
// RULE_03: Never drive the card system error line from this device.
// RULE_04: Set bit 13 when own master cycle ends with master abort.
// RULE_05: Set bit 12 when own master cycle ends with target abort.
// RULE_06: Set bit 11 when this device as target signals target abort.
// RULE_07: Bits 10 to 9 read fixed 01b, medium select timing, writes ignored.
// RULE_08: Bit 8 set on parity error line, while master, with response enabled.
// RULE_09: Bit 7 reads zero; no fast back-to-back acceptance.
// RULE_10: Bit 6 reads zero; no user-definable features.
// RULE_11: Bit 5 reads zero; link clock at most 33 MHz.
// RULE_12: Bits 4 to 0 reserved, read zero.
// RULE_13: Writing one to a sticky flag clears it.
// RULE_14: Writing zero, or writing hard-wired bits, changes nothing.
// RULE_15: Sticky flags cleared only by global reset, not function reset.
// RULE_16: Each socket function has its own independent status register.
// RULE_17: Primary bus number, 8-bit read/write, resets to 00h.
// RULE_18: Secondary bus number, 8-bit per socket, resets to zero.
// RULE_19: Forwarding compares primary, secondary and subordinate numbers together.
// RULE_20: Per-socket subordinate bus number, highest bus below the socket.
// RULE_21: Secondary number hit is local; above it up to subordinate passes.
`timescale 1ns/100ps
`default_nettype none
module cbss_top #(
  parameter int NUM_SOCK = 2,
  parameter int FUNC_W = 1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic func_reset,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [FUNC_W-1:0] cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic [NUM_SOCK-1:0] addr_data_par_err,
  input wire logic [NUM_SOCK-1:0] master_abort_rcvd,
  input wire logic [NUM_SOCK-1:0] target_abort_rcvd,
  input wire logic [NUM_SOCK-1:0] target_abort_sent,
  input wire logic [NUM_SOCK-1:0] bus_master_active,
  input wire logic [NUM_SOCK-1:0] parity_resp_en,
  input wire logic [NUM_SOCK-1:0] cclk,
  input wire logic [NUM_SOCK-1:0] cserr_n_in,
  input wire logic [NUM_SOCK-1:0] cperr_n_in,
  output logic [NUM_SOCK-1:0] cserr_n_out,
  output logic [NUM_SOCK-1:0] cserr_oe,
  input wire logic fwd_req,
  input wire logic [7:0] fwd_bus,
  output logic fwd_valid,
  output logic [NUM_SOCK-1:0] fwd_local,
  output logic [NUM_SOCK-1:0] fwd_pass
);
  // Pin synchronisers; stage 3 of the clock only finds edges
  logic [NUM_SOCK-1:0] cclk_s1, cclk_s2, cclk_s3;
  logic [NUM_SOCK-1:0] serr_s1, serr_s2, perr_s1, perr_s2;
  logic [NUM_SOCK-1:0] next_cclk_s1, next_cclk_s2, next_cclk_s3;
  logic [NUM_SOCK-1:0] next_serr_s1, next_serr_s2;
  logic [NUM_SOCK-1:0] next_perr_s1, next_perr_s2;
  logic [NUM_SOCK-1:0] cclk_rise;

  always_comb begin
    next_cclk_s1 = cclk;
    next_cclk_s2 = cclk_s1;
    next_cclk_s3 = cclk_s2;
    next_serr_s1 = cserr_n_in;
    next_serr_s2 = serr_s1;
    next_perr_s1 = cperr_n_in;
    next_perr_s2 = perr_s1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cclk_s1 <= '0;
      cclk_s2 <= '0;
      cclk_s3 <= '0;
      serr_s1 <= '1;
      serr_s2 <= '1;
      perr_s1 <= '1;
      perr_s2 <= '1;
    end else begin
      cclk_s1 <= next_cclk_s1;
      cclk_s2 <= next_cclk_s2;
      cclk_s3 <= next_cclk_s3;
      serr_s1 <= next_serr_s1;
      serr_s2 <= next_serr_s2;
      perr_s1 <= next_perr_s1;
      perr_s2 <= next_perr_s2;
    end
  end

  // Line levels share the clock's sync delay, so sampling stays aligned
  assign cclk_rise = cclk_s2 & ~cclk_s3;

  // The device only listens on the system error line
  logic [NUM_SOCK-1:0] next_serr_n_out, next_serr_oe;

  always_comb begin
    next_serr_n_out = '1;
    next_serr_oe = '0; // [RULE_03]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cserr_n_out <= '1;
      cserr_oe <= '0;
    end else begin
      cserr_n_out <= next_serr_n_out;
      cserr_oe <= next_serr_oe;
    end
  end

  // Address decode of the configuration access
  logic hit_status, hit_busnum, wr_status, wr_busnum;

  assign hit_status = cfg_addr[7:2] == cbss_pkg::OFS_SEC_STATUS[7:2];
  assign hit_busnum = cfg_addr[7:2] == cbss_pkg::OFS_PRIM_BUS[7:2];
  assign wr_status = cfg_req && cfg_we && hit_status;
  assign wr_busnum = cfg_req && cfg_we && hit_busnum;

  // Bus number registers; function reset clears them, not the flags
  logic [7:0] prim_bus, next_prim_bus;
  logic [NUM_SOCK-1:0][7:0] sec_bus, next_sec_bus;
  logic [NUM_SOCK-1:0][7:0] sub_bus, next_sub_bus;

  always_comb begin
    next_prim_bus = prim_bus;
    next_sec_bus = sec_bus;
    next_sub_bus = sub_bus;
    if (func_reset) begin
      next_prim_bus = cbss_pkg::BUS_NUM_RESET;
      next_sec_bus = '0;
      next_sub_bus = '0;
    end else if (wr_busnum) begin
      if (cfg_be[cbss_pkg::OFS_PRIM_BUS[1:0]]) begin
        next_prim_bus = cfg_wdata[7:0]; // [RULE_17]
      end
      for (int i = 0; i < NUM_SOCK; i++) begin
        if (cfg_func == FUNC_W'(i)) begin
          if (cfg_be[cbss_pkg::OFS_SEC_BUS[1:0]]) begin
            next_sec_bus[i] = cfg_wdata[15:8]; // [RULE_18]
          end
          if (cfg_be[cbss_pkg::OFS_SUB_BUS[1:0]]) begin
            next_sub_bus[i] = cfg_wdata[23:16]; // [RULE_20]
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prim_bus <= cbss_pkg::BUS_NUM_RESET;
      sec_bus <= '0;
      sub_bus <= '0;
    end else begin
      prim_bus <= next_prim_bus;
      sec_bus <= next_sec_bus;
      sub_bus <= next_sub_bus;
    end
  end

  // One status register per socket function
  cbss_flag_if fif [NUM_SOCK] ();
  logic [NUM_SOCK-1:0][15:0] sec_status;
  logic [NUM_SOCK-1:0] syserr_set, mdpar_set;

  for (genvar g = 0; g < NUM_SOCK; g++) begin : g_sock
    logic wr_this;

    assign wr_this = wr_status && cfg_func == FUNC_W'(g)
      && cfg_be[3]; // [RULE_16]
    assign syserr_set[g] = cclk_rise[g] && !serr_s2[g]; // [RULE_02]
    assign mdpar_set[g] = cclk_rise[g] && !perr_s2[g]
      && bus_master_active[g] && parity_resp_en[g]; // [RULE_08]

    assign fif[g].set_flags[cbss_pkg::FLG_PARITY] =
      addr_data_par_err[g]; // [RULE_01]
    assign fif[g].set_flags[cbss_pkg::FLG_SYSERR] = syserr_set[g];
    assign fif[g].set_flags[cbss_pkg::FLG_RX_MA] =
      master_abort_rcvd[g]; // [RULE_04]
    assign fif[g].set_flags[cbss_pkg::FLG_RX_TA] =
      target_abort_rcvd[g]; // [RULE_05]
    assign fif[g].set_flags[cbss_pkg::FLG_TX_TA] =
      target_abort_sent[g]; // [RULE_06]
    assign fif[g].set_flags[cbss_pkg::FLG_MDPAR] = mdpar_set[g];

    // Write one clears; status sits in the upper half of its dword
    for (genvar f = 0; f < cbss_pkg::NUM_FLAGS; f++) begin : g_clr
      assign fif[g].clr_flags[f] = wr_this
        && cfg_wdata[16 + cbss_pkg::FLAG_POS[f]]; // [RULE_13]
    end

    assign sec_status[g] = fif[g].status;

    cbss_status_flags u_flags (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .fi(fif[g].flag)
    );
  end

  // Read answer, one cycle after the request
  logic next_ack;
  logic [31:0] next_rdata;

  always_comb begin
    next_ack = cfg_req;
    next_rdata = 32'h0000_0000;
    if (cfg_req && !cfg_we) begin
      for (int i = 0; i < NUM_SOCK; i++) begin
        if (cfg_func == FUNC_W'(i)) begin
          if (hit_status) begin
            next_rdata = {sec_status[i], 16'h0000}; // [RULE_12]
          end else if (hit_busnum) begin
            next_rdata = {8'h00, sub_bus[i], sec_bus[i], prim_bus};
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= next_ack;
      cfg_rdata <= next_rdata;
    end
  end

  cbss_fwd_decode #(
    .NUM_SOCK(NUM_SOCK)
  ) u_fwd (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .req(fwd_req),
    .bus(fwd_bus),
    .prim(prim_bus),
    .sec(sec_bus),
    .sub(sub_bus),
    .valid(fwd_valid),
    .hit_local(fwd_local),
    .hit_pass(fwd_pass)
  );

  a_ack_timing: assert property (@(posedge sys_clk) disable iff (!resetn)
    cfg_req |=> cfg_ack ##1 !cfg_ack || $past(cfg_req))
    else $error("access answer not one cycle later");
  a_serr_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    !cserr_oe[0] && cserr_n_out[0]) // [RULE_03]
    else $error("system error line driven");
  a_syserr_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    syserr_set[0] |=> sec_status[0][14]) // [RULE_02]
    else $error("card system error not recorded");
  a_mdpar_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sec_status[0][8]) |-> $past(bus_master_active[0])
      && $past(parity_resp_en[0])) // [RULE_08]
    else $error("data parity flag set without conditions");
  a_sec_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    func_reset |=> sec_bus[0] == 8'h00 && prim_bus == 8'h00) // [RULE_18]
    else $error("function reset left bus numbers");
  a_flags_survive: assert property (@(posedge sys_clk) disable iff (!resetn)
    func_reset && sec_status[0][13] && !wr_status
      |=> sec_status[0][13]) // [RULE_15]
    else $error("function reset cleared a sticky flag");
  a_prim_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_busnum && cfg_be[0] && !func_reset
      |=> prim_bus == $past(cfg_wdata[7:0])) // [RULE_17]
    else $error("primary bus number not written");
  c_syserr: cover property (@(posedge sys_clk) disable iff (!resetn)
    syserr_set[0]);
  c_status_read: cover property (@(posedge sys_clk) disable iff (!resetn)
    cfg_req && !cfg_we && hit_status ##1 cfg_ack);
  c_local: cover property (@(posedge sys_clk) disable iff (!resetn)
    fwd_local[1]);
endmodule
`default_nettype wire

// [bench/cbss_card_model.sv]
// Card model on the far side of each socket: link clock and error lines
`timescale 1ns/100ps
`default_nettype none
module cbss_card_model #(
  parameter int NUM_SOCK = 2,
  parameter int HALF_NS = 400
) (
  output var logic [NUM_SOCK-1:0] cclk,
  output var logic [NUM_SOCK-1:0] cserr_n,
  output var logic [NUM_SOCK-1:0] cperr_n
);
  // Clock parked low, lines at pull-up level outside frames
  initial begin
    cclk = '0;
    cserr_n = '1;
    cperr_n = '1;
  end

  // Four link cycles; a line is held low across the second rising edge
  task automatic frame(input int s, input logic serr, input logic perr);
    #137;
    for (int i = 0; i < 4; i++) begin
      if (i == 1) begin
        cserr_n[s] = ~serr;
        cperr_n[s] = ~perr;
      end
      if (i == 2) begin
        cserr_n[s] = 1'b1;
        cperr_n[s] = 1'b1;
      end
      #HALF_NS cclk[s] = 1'b1;
      #HALF_NS cclk[s] = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the secondary status and bus number block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk;
  logic resetn;
  logic func_reset;
  logic cfg_req;
  logic cfg_we;
  logic [0:0] cfg_func;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata;
  logic cfg_ack;
  logic [31:0] cfg_rdata;
  logic [3:0][1:0] ev;
  logic [1:0] master;
  logic [1:0] resp_en;
  logic [1:0] cclk;
  logic [1:0] card_serr_n;
  logic [1:0] card_perr_n;
  logic [1:0] serr_wire_n;
  logic [1:0] cserr_n_out;
  logic [1:0] cserr_oe;
  logic fwd_req;
  logic [7:0] fwd_bus;
  logic fwd_valid;
  logic [1:0] fwd_local;
  logic [1:0] fwd_pass;
  int miscompares;
  int checked;
  int cycles;
  int s;
  logic [31:0] cq[$];
  logic [3:0] fq[$];
  logic [15:0] exp_st [2];
  logic [7:0] pb;
  logic [7:0] sb [2];
  logic [7:0] ub [2];
  int pos [4] = '{cbss_pkg::BIT_SEC_PARITY, cbss_pkg::BIT_RX_MASTER_ABORT,
    cbss_pkg::BIT_RX_TARGET_ABORT, cbss_pkg::BIT_TX_TARGET_ABORT};

  // Card may pull the error line low; the device's own driver joins in
  assign serr_wire_n = card_serr_n & ~(cserr_oe & ~cserr_n_out);

  cbss_top dut (.sys_clk(sys_clk), .resetn(resetn), .func_reset(func_reset),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .addr_data_par_err(ev[0]),
    .master_abort_rcvd(ev[1]), .target_abort_rcvd(ev[2]),
    .target_abort_sent(ev[3]), .bus_master_active(master),
    .parity_resp_en(resp_en), .cclk(cclk), .cserr_n_in(serr_wire_n),
    .cperr_n_in(card_perr_n), .cserr_n_out(cserr_n_out),
    .cserr_oe(cserr_oe), .fwd_req(fwd_req), .fwd_bus(fwd_bus),
    .fwd_valid(fwd_valid), .fwd_local(fwd_local), .fwd_pass(fwd_pass));

  cbss_card_model card (.cclk(cclk), .cserr_n(card_serr_n),
    .cperr_n(card_perr_n));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic cfg(logic we, logic f, logic [7:0] a, logic [3:0] be,
      logic [31:0] wd, logic [31:0] e);
    @(negedge sys_clk);
    cq.push_back(we ? 32'h0000_0000 : e);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_func = f;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = wd;
    @(negedge sys_clk);
    cfg_req = 1'b0;
  endtask

  task automatic rd_st(int f);
    cfg(1'b0, f[0], 8'h16, 4'hF, 32'h0, {exp_st[f], 16'h0000});
  endtask

  task automatic rd_all();
    rd_st(0);
    rd_st(1);
  endtask

  task automatic fwd(logic [7:0] b);
    logic [3:0] e;
    for (int f = 0; f < 2; f++) begin
      e[2 + f] = (b == sb[f]) && (b != pb);
      e[f] = (b > sb[f]) && (b <= ub[f]) && (b != pb);
    end
    @(negedge sys_clk);
    fq.push_back(e);
    fwd_req = 1'b1;
    fwd_bus = b;
    @(negedge sys_clk);
    fwd_req = 1'b0;
  endtask

  task automatic wait_n(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Monitor: results are matched to the oldest note
  always @(posedge sys_clk) begin
    #1;
    cycles++;
    if (cfg_ack === 1'b1) begin
      if (cq.size() == 0) chk("spare cfg_ack", 32'h0, 32'h1);
      else chk("cfg_rdata", cq.pop_front(), cfg_rdata);
    end
    if (fwd_valid === 1'b1) begin
      if (fq.size() == 0) chk("spare fwd_valid", 32'h0, 32'h1);
      else chk("fwd hits", {28'h0, fq.pop_front()},
        {28'h0, fwd_local, fwd_pass});
    end
    chk("cserr_oe", 32'h0, {30'h0, cserr_oe});
    chk("cserr_n_out", 32'h3, {30'h0, cserr_n_out});
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    resetn = 1'b0;
    func_reset = 1'b0;
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_func = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    ev = '0;
    master = 2'h0;
    resp_en = 2'h0;
    fwd_req = 1'b0;
    fwd_bus = 8'h00;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    exp_st = '{16'h0200, 16'h0200};
    void'($urandom(34965));
    wait_n(10);
    resetn = 1'b1;
    rd_all();
    cfg(1'b0, 1'b1, 8'h18, 4'hF, 32'h0, 32'h0);
    cfg(1'b0, 1'b0, 8'h30, 4'hF, 32'h0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      s = $urandom_range(1, 0);
      @(negedge sys_clk);
      ev[k][s] = 1'b1;
      @(negedge sys_clk);
      ev[k][s] = 1'b0;
      exp_st[s][pos[k]] = 1'b1;
      rd_all();
    end
    card.frame(0, 1'b1, 1'b0);
    exp_st[0][cbss_pkg::BIT_CARD_SYSERR] = 1'b1;
    wait_n(6);
    rd_all();
    for (int m = 0; m < 4; m++) begin
      master[1] = m[0];
      resp_en[1] = m[1];
      card.frame(1, 1'b0, 1'b1);
      exp_st[1][cbss_pkg::BIT_MASTER_DATA_PARITY] = (m == 3);
      wait_n(6);
      rd_st(1);
    end
    cfg(1'b1, 1'b0, 8'h16, 4'hF, 32'h0000_FFFF, 32'h0);
    cfg(1'b1, 1'b1, 8'h16, 4'h7, 32'hFFFF_FFFF, 32'h0);
    rd_all();
    cfg(1'b1, 1'b0, 8'h16, 4'h8, 32'h8000_0000, 32'h0);
    exp_st[0][cbss_pkg::BIT_SEC_PARITY] = 1'b0;
    rd_all();
    pb = 8'($urandom());
    cfg(1'b1, 1'b1, 8'h18, 4'h1, {24'h0, pb}, 32'h0);
    for (int f = 0; f < 2; f++) begin
      sb[f] = 8'($urandom_range(250, 0));
      ub[f] = sb[f] + 8'($urandom_range(3, 0));
      cfg(1'b1, f[0], 8'h19, 4'h6, {8'h0, ub[f], sb[f], 8'h0}, 32'h0);
    end
    for (int f = 0; f < 2; f++) begin
      cfg(1'b0, f[0], 8'h1A, 4'hF, 32'h0,
        {8'h0, ub[f], sb[f], pb});
      fwd(pb);
      fwd(sb[f]);
      fwd(sb[f] + 8'h01);
      fwd(ub[f]);
      fwd(ub[f] + 8'h01);
    end
    @(negedge sys_clk);
    func_reset = 1'b1;
    @(negedge sys_clk);
    func_reset = 1'b0;
    cfg(1'b0, 1'b1, 8'h18, 4'hF, 32'h0, 32'h0);
    rd_all();
    cfg(1'b1, 1'b1, 8'h16, 4'hF, 32'hFFFF_FFFF, 32'h0);
    exp_st[1] = 16'h0200;
    rd_all();
    wait_n(2);
    resetn = 1'b0;
    exp_st = '{16'h0200, 16'h0200};
    wait_n(3);
    resetn = 1'b1;
    rd_all();
    wait_n(3);
    chk("pending notes", 32'h0, 32'(cq.size() + fq.size()));
    close_out();
  end
endmodule
`default_nettype wire
